// File: hdl/oag_core.sv
// operand address generator: decodes source and destination
// modes, forms effective addresses, applies register write-back.
// assumes the core presents fetched index words with the request
// and that all inputs come from logic on clk.
`timescale 1ns/100ps
`default_nettype none

module oag_core
   import oag_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [oag_pkg::RAW-1:0] regAddr,
   input wire logic [oag_pkg::DW-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [oag_pkg::DW-1:0] regRdata,
   // decode request from the core
   input wire logic reqValid,
   input wire logic [1:0] srcMode,
   input wire logic [3:0] srcSel,
   input wire logic dstMode,
   input wire logic [3:0] dstSel,
   input wire logic byteWord,
   input wire logic extPresent,
   input wire logic extAddrLen,
   input wire logic [3:0] extSrcHi,
   input wire logic [3:0] extDstHi,
   input wire logic [oag_pkg::AW-1:0] srcRegValue,
   input wire logic [oag_pkg::AW-1:0] dstRegValue,
   input wire logic [oag_pkg::AW-1:0] pcValue,
   input wire logic [15:0] srcIndexWord,
   input wire logic [15:0] dstIndexWord,
   // decode answer
   output logic decValid,
   output logic srcUseReg,
   output logic srcMemRd,
   output logic srcImm,
   output logic [oag_pkg::AW-1:0] srcAddr,
   output logic [oag_pkg::AW-1:0] srcImmValue,
   output logic dstUseReg,
   output logic dstMemAcc,
   output logic [oag_pkg::AW-1:0] dstAddr,
   output logic [1:0] dataSize,
   output logic [2:0] instrWords,
   output logic incValid,
   output logic [3:0] incSel,
   output logic [oag_pkg::AW-1:0] incValue,
   // destination register write-back
   input wire logic wbValid,
   input wire logic [3:0] wbSel,
   input wire logic [1:0] wbSize,
   input wire logic wbSignExt,
   input wire logic [oag_pkg::AW-1:0] wbResult,
   output logic regWrValid,
   output logic [3:0] regWrSel,
   output logic [oag_pkg::AW-1:0] regWrData
);
   import oag_pkg::*;

   ////////////////////////////////////////////////////////////
   // address arithmetic

   // effective address from base and index; the 20-bit
   // sum drops its carry and wraps in 1 MB; a short index on a low-segment base wraps in 64 KB
   function automatic logic [AW-1:0] effAddr(
      input logic [AW-1:0] base,
      input logic [15:0] idx,
      input logic ext,
      input logic [3:0] hi
   );
      logic [AW-1:0] lowSum;
      lowSum = base + {4'h0, idx};
      if (ext)
         effAddr = base + {hi, idx};
      else if (base[19:16] == LOW_SEG)
         effAddr = {LOW_SEG, lowSum[15:0]};
      else
         effAddr = base + {{4{idx[15]}}, idx};
   endfunction

   ////////////////////////////////////////////////////////////
   // control and status registers

   logic enable; // decoder on
   logic [15:0] decCount; // decodes done
   logic [AW-1:0] lastSrc; // last source address
   logic [AW-1:0] lastDst; // last destination address
   logic take; // request accepted this cycle

   // requests while disabled are dropped silently
   assign take = reqValid && enable;

   // control register write
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         enable <= CTRL_RST;
      else if (regWr && regAddr == OFS_CTRL)
         enable <= regWdata[CTRL_EN_BIT];
   end

   // decode counter; a software write clears it, but a
   // decode in the same cycle still counts
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         decCount <= COUNT_RST;
      else if (regWr && regAddr == OFS_COUNT)
         decCount <= {15'h0, take};
      else if (take)
         decCount <= decCount + 16'h0001;
   end

   // read data, valid only the cycle after the strobe
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         regRdata <= '0;
      else if (!regRd)
         regRdata <= '0;
      else
      begin
         case (regAddr)
            OFS_CTRL: regRdata <= {31'h0, enable};
            OFS_COUNT: regRdata <= {16'h0, decCount};
            OFS_LSRC: regRdata <= {12'h0, lastSrc};
            OFS_LDST: regRdata <= {12'h0, lastDst};
            default: regRdata <= '0; // unmapped reads zero
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // combinational decode

   logic [1:0] next_size;
   logic [AW-1:0] next_srcAddr;
   logic [AW-1:0] next_dstAddr;
   logic [AW-1:0] next_imm;
   logic [AW-1:0] next_step;
   logic [AW-1:0] srcBase; // base for mode one
   logic [AW-1:0] dstBase;
   logic [2:0] next_words;
   logic srcIsImm; // immediate form
   logic srcIsInc; // general autoincrement

   // data size from the length and byte/word bits
   always_comb
   begin
      if (extPresent && !extAddrLen && byteWord)
         next_size = SIZE_AWORD;
      else if (byteWord)
         next_size = SIZE_BYTE;
      else
         next_size = SIZE_WORD;
   end

   // autoincrement step per size
   always_comb
   begin
      case (next_size)
         SIZE_BYTE: next_step = INC_BYTE;
         SIZE_WORD: next_step = INC_WORD;
         SIZE_AWORD: next_step = INC_AWORD;
         default: next_step = INC_WORD;
      endcase
   end

   // base choice: counter, zero for status, else register
   always_comb
   begin
      if (srcSel == REG_PC)
         srcBase = pcValue;
      else if (srcSel == REG_SR)
         srcBase = ADDR_RST;
      else
         srcBase = srcRegValue;
      if (dstSel == REG_PC)
         dstBase = pcValue;
      else if (dstSel == REG_SR)
         dstBase = ADDR_RST;
      else
         dstBase = dstRegValue;
   end

   assign srcIsImm = srcMode == MODE_INC && srcSel == REG_PC;
   assign srcIsInc = srcMode == MODE_INC && srcSel != REG_PC;

   // source address per mode
   always_comb
   begin
      case (srcMode)
         MODE_IDX: next_srcAddr =
            effAddr(srcBase, srcIndexWord, extPresent, extSrcHi);
         MODE_IND: next_srcAddr = srcRegValue;
         MODE_INC: next_srcAddr = srcRegValue;
         default: next_srcAddr = ADDR_RST;
      endcase
   end

   // destination has one mode bit only
   always_comb
   begin
      if (dstMode)
         next_dstAddr =
            effAddr(dstBase, dstIndexWord, extPresent, extDstHi);
      else
         next_dstAddr = ADDR_RST;
   end

   // immediate value, upper bits from extension
   always_comb
   begin
      if (extPresent)
         next_imm = {extSrcHi, srcIndexWord};
      else
         next_imm = {4'h0, srcIndexWord};
   end

   // length: opcode, extension, source word, destination word
   always_comb
   begin
      next_words = 3'd1;
      if (extPresent)
         next_words = next_words + 3'd1;
      if (srcMode == MODE_IDX || srcIsImm)
         next_words = next_words + 3'd1;
      if (dstMode)
         next_words = next_words + 3'd1;
   end

   ////////////////////////////////////////////////////////////
   // registered decode answer

   // answer pulse and its fields
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         decValid <= 1'b0;
         srcUseReg <= 1'b0;
         srcMemRd <= 1'b0;
         srcImm <= 1'b0;
         dstUseReg <= 1'b0;
         dstMemAcc <= 1'b0;
      end
      else
      begin
         decValid <= take;
         srcUseReg <= take && srcMode == MODE_REG;
         srcMemRd <= take && srcMode != MODE_REG && !srcIsImm;
         srcImm <= take && srcIsImm;
         dstUseReg <= take && !dstMode;
         dstMemAcc <= take && dstMode;
      end
   end

   // answer data held until the next request
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         srcAddr <= ADDR_RST;
         dstAddr <= ADDR_RST;
         srcImmValue <= ADDR_RST;
         dataSize <= SIZE_WORD;
         instrWords <= 3'd1;
      end
      else if (take)
      begin
         srcAddr <= next_srcAddr;
         dstAddr <= next_dstAddr;
         srcImmValue <= next_imm;
         dataSize <= next_size;
         instrWords <= next_words;
      end
   end

   // last addresses for software
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lastSrc <= ADDR_RST;
         lastDst <= ADDR_RST;
      end
      else if (take)
      begin
         lastSrc <= next_srcAddr;
         lastDst <= next_dstAddr;
      end
   end

   // pointer step; the counter's own step for immediates is
   // already covered by the instruction length
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         incValid <= 1'b0;
         incSel <= 4'h0;
         incValue <= ADDR_RST;
      end
      else
      begin
         incValid <= take && srcIsInc;
         incSel <= srcSel;
         incValue <= srcRegValue + next_step;
      end
   end

   ////////////////////////////////////////////////////////////
   // destination register write-back

   logic [AW-1:0] next_wbData;

   // size shaping of the result
   always_comb
   begin
      if (wbSignExt)
         next_wbData = {{12{wbResult[7]}}, wbResult[7:0]};
      else
      begin
         case (wbSize)
            SIZE_BYTE: next_wbData = {12'h0, wbResult[7:0]};
            SIZE_WORD: next_wbData = {4'h0, wbResult[15:0]};
            SIZE_AWORD: next_wbData = wbResult;
            default: next_wbData = {4'h0, wbResult[15:0]};
         endcase
      end
   end

   // only the destination is written; source stays as is
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         regWrValid <= 1'b0;
         regWrSel <= 4'h0;
         regWrData <= ADDR_RST;
      end
      else
      begin
         regWrValid <= wbValid;
         regWrSel <= wbSel;
         regWrData <= next_wbData;
      end
   end

   ////////////////////////////////////////////////////////////
   // checks

   a_reg_direct: assert property (
      @(posedge clk) disable iff (rst)
      take && srcMode == MODE_REG |=> srcUseReg && !srcMemRd)
      else $error("register mode caused memory read");

   a_low_trunc: assert property (
      @(posedge clk) disable iff (rst)
      take && srcMode == MODE_IDX && !extPresent
      && srcSel > REG_SR && srcRegValue[19:16] == LOW_SEG
      |=> srcAddr[19:16] == LOW_SEG)
      else $error("low-segment index left 64K");

   a_high_sext: assert property (
      @(posedge clk) disable iff (rst)
      take && dstMode && !extPresent && dstSel > REG_SR
      && dstRegValue[19:16] != LOW_SEG
      |=> dstAddr == $past(dstRegValue)
      + {{4{$past(dstIndexWord[15])}}, $past(dstIndexWord)})
      else $error("high base sum wrong");

   a_abs_base: assert property (
      @(posedge clk) disable iff (rst)
      take && srcMode == MODE_IDX && srcSel == REG_SR
      && !extPresent
      |=> srcAddr == {4'h0, $past(srcIndexWord)})
      else $error("absolute address wrong");

   a_ext_index: assert property (
      @(posedge clk) disable iff (rst)
      take && srcMode == MODE_IDX && extPresent && srcSel > REG_SR
      |=> srcAddr == $past(srcRegValue)
      + {$past(extSrcHi), $past(srcIndexWord)})
      else $error("extended index sum wrong");

   a_indirect_ptr: assert property (
      @(posedge clk) disable iff (rst)
      take && srcMode == MODE_IND
      |=> srcMemRd && srcAddr == $past(srcRegValue))
      else $error("indirect pointer wrong");

   a_inc_step: assert property (
      @(posedge clk) disable iff (rst)
      take && srcIsInc && byteWord && !extPresent
      |=> incValid && incValue == $past(srcRegValue) + 20'h0_0001)
      else $error("byte step not one");

   a_imm_nomem: assert property (
      @(posedge clk) disable iff (rst)
      take && srcIsImm |=> srcImm && !srcMemRd && !incValid)
      else $error("immediate misdecoded");

   a_byte_clear: assert property (
      @(posedge clk) disable iff (rst)
      wbValid && !wbSignExt && wbSize == SIZE_BYTE
      |=> regWrValid && regWrData[19:8] == 12'h000)
      else $error("byte write kept upper bits");

   a_sign_ext: assert property (
      @(posedge clk) disable iff (rst)
      wbValid && wbSignExt
      |=> regWrData[19:8] == {12{$past(wbResult[7])}})
      else $error("sign extension wrong");

endmodule // oag_core
`default_nettype wire

// File: inc/oag_pkg.sv
// operand address generator: shared constants
// assumes a 20-bit address space and 16-bit words
`default_nettype none
package oag_pkg;
   // widths
   localparam int AW = 20;
   localparam int DW = 32;
   localparam int RAW = 4;
   // register map, byte offsets
   localparam logic [RAW-1:0] OFS_CTRL = 4'h0;
   localparam logic [RAW-1:0] OFS_COUNT = 4'h4;
   localparam logic [RAW-1:0] OFS_LSRC = 4'h8;
   localparam logic [RAW-1:0] OFS_LDST = 4'hC;
   // reset values
   localparam logic CTRL_RST = 1'b1;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [AW-1:0] ADDR_RST = 20'h0_0000;
   // control bit positions
   localparam int CTRL_EN_BIT = 0;
   // special register numbers
   localparam logic [3:0] REG_PC = 4'h0;
   localparam logic [3:0] REG_SR = 4'h2;
   // source mode codes
   localparam logic [1:0] MODE_REG = 2'h0;
   localparam logic [1:0] MODE_IDX = 2'h1;
   localparam logic [1:0] MODE_IND = 2'h2;
   localparam logic [1:0] MODE_INC = 2'h3;
   // data size codes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_AWORD = 2'h2;
   // autoincrement steps
   localparam logic [AW-1:0] INC_BYTE = 20'h0_0001;
   localparam logic [AW-1:0] INC_WORD = 20'h0_0002;
   localparam logic [AW-1:0] INC_AWORD = 20'h0_0004;
   // upper nibble that marks the lower 64 KB
   localparam logic [3:0] LOW_SEG = 4'h0;
endpackage
`default_nettype wire

// File: dv/oag_mem_model.sv
// data memory partner: answers operand reads issued by the decoder
// assumes one clock shared with the decoder and an active-high async reset
`timescale 1ns/100ps
`default_nettype none
module oag_mem_model
   import oag_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic rdEn,
   input wire logic [oag_pkg::AW-1:0] addr,
   output logic [15:0] rdData
);
   ////////////////////////////////////////////////////////////////////////
   // read answer: a pattern of the address, toggled when idle
   // so that a word one cycle stale cannot pass for a fresh one
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdData <= 16'h0000;
      else if (rdEn)
         rdData <= addr[15:0] ^ 16'hA5A5;
      else
         rdData <= ~rdData;
   end
endmodule // oag_mem_model
`default_nettype wire

// File: dv/operand_address_generator_tb_top.sv
// testbench for the operand address generator
// assumes oag_pkg compiled first; expected values queued by drivers
`timescale 1ns/100ps
`default_nettype none
module operand_address_generator_tb_top;
   import oag_pkg::*;
   // one expected decode answer
   typedef struct packed {logic [4:0] fl; logic [AW-1:0] sa; logic [AW-1:0] da; logic [1:0] sz; logic [2:0] nw;} oag_exp_t;
   logic clk, rst, regWr, regRd, reqValid, dstMode, byteWord, extPresent, extAddrLen;
   logic [RAW-1:0] regAddr;
   logic [DW-1:0] regWdata, regRdata;
   logic [1:0] srcMode, dataSize, wbSize;
   logic [3:0] srcSel, dstSel, extSrcHi, extDstHi, incSel, wbSel, regWrSel;
   logic [AW-1:0] srcRegValue, dstRegValue, pcValue, srcAddr, srcImmValue, dstAddr, incValue, wbResult, regWrData;
   logic [15:0] srcIndexWord, dstIndexWord;
   logic decValid, srcUseReg, srcMemRd, srcImm, dstUseReg, dstMemAcc, incValid, wbValid, wbSignExt, regWrValid;
   logic [2:0] instrWords;
   // scoreboard queues and counters
   oag_exp_t expQ[$];
   logic [23:0] incQ[$];
   logic [AW-1:0] wbQ[$];
   logic [DW-1:0] rdQ[$];
   logic rdPend = 1'b0;
   logic enable = 1'b1;
   int miscompares = 0;
   int checks = 0;
   int seed = 45860;
   // destination register number used by req; symbolic and absolute tests move it
   logic [3:0] dSel = 4'h6;
   // partner read data and its pending expectation, one cycle behind the answer
   logic [15:0] memData;
   logic [15:0] memExp;
   logic memPend = 1'b0;
   oag_core oag_core_i (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .reqValid, .srcMode,
      .srcSel, .dstMode, .dstSel, .byteWord, .extPresent, .extAddrLen, .extSrcHi, .extDstHi, .srcRegValue,
      .dstRegValue, .pcValue, .srcIndexWord, .dstIndexWord, .decValid, .srcUseReg, .srcMemRd, .srcImm,
      .srcAddr, .srcImmValue, .dstUseReg, .dstMemAcc, .dstAddr, .dataSize, .instrWords, .incValid, .incSel,
      .incValue, .wbValid, .wbSel, .wbSize, .wbSignExt, .wbResult, .regWrValid, .regWrSel, .regWrData);
   // memory partner sees only the source read strobe
   oag_mem_model oag_mem_model_i (.clk, .rst, .rdEn(srcMemRd), .addr(srcAddr), .rdData(memData));
   ////////////////////////////////////////////////////////////////////////
   // clock, 4 ns period
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (e !== g)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // expected index sum: short index truncates in the low segment
   function automatic logic [AW-1:0] ixa(input logic [AW-1:0] b, input logic [15:0] i, input logic x,
      input logic [3:0] h);
      if (x)
         return b + {h, i};
      if (b[19:16] == 4'h0)
         return {4'h0, b[15:0] + i};
      return b + {{4{i[15]}}, i};
   endfunction
   task automatic wr(input logic [RAW-1:0] a, input logic [DW-1:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [RAW-1:0] a, input logic [DW-1:0] e);
      rdQ.push_back(e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
   endtask
   // decode request; holds reqValid so calls may run back to back
   task automatic req(input logic [1:0] m, input logic [3:0] s, input logic [AW-1:0] sv, input logic [15:0] si,
      input logic [3:0] sh, input logic dm, input logic [AW-1:0] dv, input logic [15:0] di, input logic [3:0] dh,
      input logic ex, input logic [1:0] sz, input logic [AW-1:0] pc);
      oag_exp_t e;
      logic [AW-1:0] b;
      logic [AW-1:0] db;
      logic im;
      im = (m == MODE_INC) && (s == REG_PC);
      b = (s == REG_PC) ? pc : (s == REG_SR) ? 20'h0_0000 : sv;
      db = (dSel == REG_PC) ? pc : (dSel == REG_SR) ? 20'h0_0000 : dv;
      e.fl = {m == MODE_REG, m != MODE_REG && !im, im, !dm, dm};
      // immediates carry the expected value, memory forms the address
      e.sa = (m == MODE_IDX) ? ixa(b, si, ex, sh) : im ? {(ex ? sh : 4'h0), si} : sv;
      e.da = ixa(db, di, ex, dh);
      e.sz = sz;
      e.nw = 3'd1 + 3'(ex) + 3'(m == MODE_IDX || im) + 3'(dm);
      if (enable)
      begin
         expQ.push_back(e);
         if (m == MODE_INC && !im)
            incQ.push_back({s, sv + (sz == SIZE_BYTE ? INC_BYTE : sz == SIZE_WORD ? INC_WORD : INC_AWORD)});
      end
      reqValid <= 1'b1;
      srcMode <= m;
      srcSel <= s;
      srcRegValue <= sv;
      srcIndexWord <= si;
      extSrcHi <= sh;
      dstMode <= dm;
      dstSel <= dSel;
      dstRegValue <= dv;
      dstIndexWord <= di;
      extDstHi <= dh;
      extPresent <= ex;
      byteWord <= (sz != SIZE_WORD);
      extAddrLen <= (sz != SIZE_AWORD);
      pcValue <= pc;
      @(posedge clk);
   endtask
   task automatic idle();
      reqValid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wb(input logic [1:0] sz, input logic sx, input logic [AW-1:0] r, input logic [AW-1:0] e);
      wbQ.push_back(e);
      wbValid <= 1'b1;
      wbSel <= 4'h7;
      wbSize <= sz;
      wbSignExt <= sx;
      wbResult <= r;
      @(posedge clk);
      wbValid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic end_of_test();
      chk("queues empty", 64'(0), 64'(expQ.size() + incQ.size() + wbQ.size() + rdQ.size()));
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // monitor: a result on the outputs retires the oldest note
   always @(posedge clk) rdPend <= regRd;
   always @(negedge clk)
   begin
      oag_exp_t e;
      if (memPend) chk("memData", 64'(memExp), 64'(memData));
      memPend = 1'b0;
      if (decValid === 1'b1)
      begin
         e = (expQ.size() > 0) ? expQ.pop_front() : '0;
         chk("flags", 64'(e.fl), 64'({srcUseReg, srcMemRd, srcImm, dstUseReg, dstMemAcc}));
         if (e.fl[3]) chk("srcAddr", 64'(e.sa), 64'(srcAddr));
         if (e.fl[2]) chk("srcImmValue", 64'(e.sa), 64'(srcImmValue));
         // the partner answers the read at the next edge
         memPend = e.fl[3];
         memExp = e.sa[15:0] ^ 16'hA5A5;
         if (e.fl[0]) chk("dstAddr", 64'(e.da), 64'(dstAddr));
         chk("dataSize", 64'(e.sz), 64'(dataSize));
         chk("instrWords", 64'(e.nw), 64'(instrWords));
      end
      if (incValid === 1'b1)
         chk("inc", 64'((incQ.size() > 0) ? incQ.pop_front() : 24'h0), 64'({incSel, incValue}));
      if (regWrValid === 1'b1)
         chk("regWrData", 64'((wbQ.size() > 0) ? wbQ.pop_front() : 20'h0), 64'(regWrData));
      if (rdPend)
         chk("regRdata", 64'((rdQ.size() > 0) ? rdQ.pop_front() : 32'h0), 64'(regRdata));
   end
   ////////////////////////////////////////////////////////////////////////
   // watchdog, far beyond the 127 cycles the tests need
   initial
   begin
      #20000;
      miscompares++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      logic [AW-1:0] r;
      logic [1:0] m, sz;
      logic [3:0] s;
      logic x;
      {regWr, regRd, reqValid, wbValid, wbSignExt, dstMode, byteWord, extPresent, extAddrLen} = '0;
      {regAddr, regWdata, srcMode, wbSize, srcSel, dstSel, extSrcHi, extDstHi, wbSel} = '0;
      {srcRegValue, dstRegValue, pcValue, wbResult, srcIndexWord, dstIndexWord} = '0;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset values and an unmapped place
      rd(OFS_CTRL, 32'h0000_0001);
      rd(OFS_COUNT, 32'h0000_0000);
      rd(4'h6, 32'h0000_0000);
      $display("register test done");
      // indexed, symbolic, absolute and extended forms, back to back
      req(MODE_IDX, 4'h5, 20'h0_479C, 16'h1000, 4'h0, 1'b1, 20'h0_2778, 16'hF000, 4'h0, 1'b0, SIZE_BYTE, 20'h0);
      req(MODE_IDX, 4'h5, 20'h2_3456, 16'h8346, 4'h0, 1'b1, 20'h1_5678, 16'h2100, 4'h0, 1'b0, SIZE_WORD, 20'h0);
      req(MODE_IDX, 4'h5, 20'h2_3456, 16'h2346, 4'h1, 1'b1, 20'h4_5678, 16'h2100, 4'h3, 1'b1, SIZE_AWORD, 20'h0);
      req(MODE_IDX, REG_PC, 20'h5_5555, 16'h4766, 4'h0, 1'b0, 20'h0, 16'h0, 4'h0, 1'b0, SIZE_BYTE, 20'h0_1036);
      req(MODE_IDX, REG_PC, 20'h0, 16'h4766, 4'h0, 1'b0, 20'h0, 16'h0, 4'h0, 1'b0, SIZE_WORD, 20'h2_F036);
      req(MODE_IDX, REG_PC, 20'h0, 16'h4766, 4'h1, 1'b0, 20'h0, 16'h0, 4'h0, 1'b1, SIZE_BYTE, 20'h2_1036);
      req(MODE_IDX, REG_SR, 20'hA_AAAA, 16'h0778, 4'h0, 1'b1, 20'h0, 16'h0778, 4'h0, 1'b0, SIZE_WORD, 20'h0);
      req(MODE_IDX, 4'h5, 20'hF_FFF0, 16'h0020, 4'h0, 1'b0, 20'h0, 16'h0, 4'h0, 1'b1, SIZE_WORD, 20'h0);
      idle();
      rd(OFS_COUNT, 32'h0000_0008);
      rd(OFS_LSRC, 32'h0000_0010);
      wr(OFS_COUNT, 32'h0000_0000);
      $display("indexed test done");
      // register, indirect, autoincrement and immediate over all sizes
      for (int i = 0; i < 3; i++)
      begin
         sz = 2'(i);
         x = (sz == SIZE_AWORD);
         r = 20'($random(seed));
         req(MODE_REG, 4'h5, r, 16'h0, 4'h0, 1'b0, r, 16'h0, 4'h0, x, sz, 20'h0);
         req(MODE_IND, 4'h5, r, 16'h0, 4'h0, 1'b0, r, 16'h0, 4'h0, x, sz, 20'h0);
         req(MODE_INC, 4'h9, r, 16'h0, 4'h0, 1'b1, r, 16'h1234, 4'h0, x, sz, 20'h0);
         req(MODE_INC, REG_PC, r, 16'hBEEF, 4'h0, 1'b0, r, 16'h0, 4'h0, x, sz, r);
      end
      // random pairings of source and destination modes
      for (int i = 0; i < 24; i++)
      begin
         m = 2'($random(seed));
         s = (m >= MODE_IND) ? 4'h9 : 4'h5;
         if (i % 3 == 0)
            s = (m == MODE_IND) ? 4'h5 : REG_PC;
         x = 1'($random(seed));
         sz = x ? 2'($unsigned($random(seed)) % 3) : 2'($unsigned($random(seed)) % 2);
         req(m, s, 20'($random(seed)), 16'($random(seed)), 4'($random(seed)), 1'($random(seed)),
            20'($random(seed)), 16'($random(seed)), 4'($random(seed)), x, sz, 20'($random(seed)));
      end
      idle();
      $display("mode test done");
      // disabled decoder refuses requests
      wr(OFS_CTRL, 32'h0000_0000);
      enable = 1'b0;
      req(MODE_IDX, 4'h5, 20'h1_0000, 16'h0001, 4'h0, 1'b0, 20'h0, 16'h0, 4'h0, 1'b0, SIZE_WORD, 20'h0);
      idle();
      rd(OFS_CTRL, 32'h0000_0000);
      rd(OFS_COUNT, 32'h0000_0024);
      wr(OFS_CTRL, 32'h0000_0001);
      enable = 1'b1;
      $display("enable test done");
      // symbolic and absolute destinations
      dSel = REG_PC;
      req(MODE_REG, 4'h5, 20'h1_1111, 16'h0, 4'h0, 1'b1, 20'h0, 16'hF740, 4'h0, 1'b0, SIZE_BYTE, 20'h0_1038);
      dSel = REG_SR;
      req(MODE_IND, 4'h5, 20'h0_0800, 16'h0, 4'h0, 1'b1, 20'h0, 16'h2345, 4'h1, 1'b1, SIZE_WORD, 20'h0);
      dSel = 4'h6;
      idle();
      rd(OFS_LDST, 32'h0001_2345);
      $display("destination test done");
      // register write-back: clearing per size, sign extension
      for (int i = 0; i < 4; i++)
      begin
         r = 20'($random(seed)) | 20'h0_0080;
         wb(SIZE_BYTE, 1'b0, r, {12'h000, r[7:0]});
         wb(SIZE_WORD, 1'b0, r, {4'h0, r[15:0]});
         wb(SIZE_AWORD, 1'b0, r, r);
         wb(2'(i), 1'b1, r ^ 20'h0_0080, {{12{~r[7]}}, ~r[7], r[6:0]});
         wb(2'(i), 1'b1, r, {12'hFFF, r[7:0]});
      end
      repeat (3) @(posedge clk);
      $display("write-back test done");
      end_of_test();
   end
endmodule // operand_address_generator_tb_top
`default_nettype wire
